// file: hdl/ftrc_map.svh
`ifndef FTRC_MAP_SVH
`define FTRC_MAP_SVH
`define FTRC_ADDR_W        15
`define FTRC_EXP_MAX       7'h63
`define FTRC_NOTERM_POS    2'h3
`define FTRC_IND_HP        4'hB
`define FTRC_IND_EZ        4'hC
`define FTRC_IND_AC        4'hE
`define FTRC_IND_EC        4'hF
`define FTRC_OP_TFL        7'h06
`define FTRC_OP_BTF        7'h07
`define FTRC_OP_CMP        7'h18
`define FTRC_T_TFL_BASE_US 240
`define FTRC_T_PER_DIG_US  40
`define FTRC_CLK_MHZ       20
`define FTRC_WAIT_W        18
`define FTRC_INSN_LEN      15'h000C
`endif

// file: hdl/ftrc_pkg.sv
package ftrc_pkg;
   typedef enum logic [2:0] {
      FTRC_IDLE = 3'h0,
      FTRC_READ = 3'h1,
      FTRC_WRIT = 3'h3,
      FTRC_WAIT = 3'h2,
      FTRC_DONE = 3'h6
   } ftrc_state_e;

   typedef struct packed {
      logic [3:0] digit;
      logic       flag;
   } ftrc_char_s;

   typedef struct packed {
      logic       valid;
      logic       negative;
      logic       zeroMant;
      logic       divZero;
      logic       opZero;
      logic [8:0] expSum;
      logic [7:0] leadZeros;
   } ftrc_result_s;

   typedef struct packed {
      logic       hp;
      logic       ez;
      logic       ac;
      logic       ec;
   } ftrc_ind_s;

   typedef struct packed {
      ftrc_state_e state;
      logic [14:0] srcAddr;
      logic [14:0] dstAddr;
      logic [14:0] retAddr;
      logic [14:0] firstExpAddr;
      logic [14:0] secondExpAddr;
      logic [8:0]  expDiff;
      logic [7:0]  pos;
      logic [17:0] waitCnt;
      ftrc_char_s  data;
      ftrc_ind_s   ind;
      logic        branch;
   } ftrc_state_s;
endpackage

// file: hdl/ftrc_unit.sv
`timescale 1ns/1ps
`include "ftrc_map.svh"
// Notes on behaviour
// RULE1: Transmit floating copies; flags end from fourth.
// RULE2: Branch-transmit saves return, copies to P-1.
// RULE3: Branch-transmit ignores low three flags.
// RULE4: Zero mantissa becomes special zero, exponent -99.
// RULE5: Zero mantissa sets equal/zero indicator.
// RULE6: Positive mantissa sets high/positive indicator.
// RULE7: Divide by zero sets arithmetic check.
// RULE8: Exponent over/underflow sets exponent check.
// RULE9: Overflow: nines, keep sign, exponent +99.
// RULE10: Underflow: plus zeros, exponent -99, set E/Z.
// RULE11: No underflow signalled for zero operands.
// RULE12: Overflow switch governs checks' program flow.
// RULE13: Exponent check clears on test or reset.
// RULE14: Each indicator drives its console lamp.
// RULE15: Internal registers hold both exponent addresses.
// RULE16: Counter holds exponent difference, leading zeros.
// RULE17: Programs supply zeros in special zero form.
// RULE18: Transmit floating takes 240+40L microseconds.
// RULE19: Compare subtracts, discards, leaves fields unaltered.
// RULE20: Compare reports via indicators only.
// RULE21: Equal compare clears H/P, sets E/Z.
module ftrc_unit #(
   parameter int ADDR_W = `FTRC_ADDR_W
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   input  wire logic                 start,
   input  wire logic [6:0]           opCode,
   input  wire logic [ADDR_W-1:0]    pAddr,
   input  wire logic [ADDR_W-1:0]    qAddr,
   input  wire logic [ADDR_W-1:0]    instrAddr,
   input  wire logic [7:0]           mantLen,
   output logic                      memRead,
   output logic                      memWrite,
   output logic [ADDR_W-1:0]         memAddr,
   output ftrc_pkg::ftrc_char_s      memWrData,
   input  wire ftrc_pkg::ftrc_char_s memRdData,
   output logic                      busy,
   output logic                      done,
   output logic                      branchTaken,
   output logic [ADDR_W-1:0]         nextInstrAddr,
   output logic [ADDR_W-1:0]         returnAddress,
   input  wire ftrc_pkg::ftrc_result_s result,
   output logic                      resultZeroFill,
   output logic                      resultNineFill,
   output logic                      resultNegative,
   output logic [7:0]                resultExp,
   output logic                      resultExpNeg,
   input  wire logic                 cmpValid,
   input  wire logic                 cmpGreater,
   input  wire logic                 cmpEqual,
   input  wire logic [ADDR_W-1:0]    firstExpAddrIn,
   input  wire logic [ADDR_W-1:0]    secondExpAddrIn,
   input  wire logic                 expAddrLoad,
   output logic [ADDR_W-1:0]         firstExpAddr,
   output logic [ADDR_W-1:0]         secondExpAddr,
   output logic [8:0]                expDiff,
   input  wire logic                 expCheckTest,
   input  wire logic                 operatorReset,
   input  wire logic                 overflowCheckSw,
   output logic                      expCheckTestResult,
   output logic                      checkStop,
   output logic                      lampHighPos,
   output logic                      lampEqualZero,
   output logic                      lampArithCheck,
   output logic                      lampExpCheck
);
   localparam int CYC_PER_US = `FTRC_CLK_MHZ;
   localparam int BASE_CYC   = `FTRC_T_TFL_BASE_US * CYC_PER_US;
   localparam int DIG_CYC    = `FTRC_T_PER_DIG_US * CYC_PER_US;
   localparam int CNT_W      = `FTRC_WAIT_W;

   ftrc_pkg::ftrc_state_s s_q;
   ftrc_pkg::ftrc_state_s s_d;
   logic                  isBtf;
   logic                  isCopy;
   logic                  ovf;
   logic                  unf;
   logic                  stopFlag;
   logic                  ecSet;
   logic                  ecClr;
   logic                  acSet;
   logic                  acClr;
   logic [8:0]            normExp;
   logic [CNT_W-1:0]      tflCycles;

   // Instruction decode; only the two floating copies start the sequencer.
   assign isBtf  = (opCode == `FTRC_OP_BTF);
   assign isCopy = (opCode == `FTRC_OP_TFL) || isBtf;

   // Exponent after normalisation, as a signed 9-bit value.
   assign normExp = result.expSum - 9'(result.leadZeros); // RULE16
   assign ovf = result.valid && !normExp[8] && (normExp > 9'(`FTRC_EXP_MAX));
   // Zero operands suppress underflow.
   assign unf = result.valid && normExp[8] && (normExp < -9'(`FTRC_EXP_MAX))
                && !result.opZero; // RULE11

   // Total copy time. The counter is wide enough for the longest mantissa
   // length, so a long field never wraps the wait short. The digit loop
   // runs inside this time and does not add to it.
   assign tflCycles = CNT_W'(BASE_CYC + DIG_CYC * int'(mantLen)); // RULE18

   // A flag ends the copy only from the fourth character on. The character
   // is written in the same cycle as the test, so every flag met is copied as well.
   assign stopFlag = s_q.data.flag && (s_q.pos >= 8'(`FTRC_NOTERM_POS)); // RULE1 RULE3

   // Check indicator events. Clears are applied before sets further down,
   // so a check raised in the cycle of a test or a reset is never lost.
   assign ecSet = ovf || unf; // RULE8
   assign ecClr = expCheckTest || operatorReset; // RULE13
   assign acSet = result.valid && result.divZero; // RULE7
   assign acClr = operatorReset;

   always_comb begin
      s_d       = s_q;
      memRead   = 1'b0;
      memWrite  = 1'b0;
      memAddr   = s_q.srcAddr;
      done      = 1'b0;
      if (s_q.waitCnt != '0) begin
         s_d.waitCnt = s_q.waitCnt - CNT_W'(1);
      end

      // Copy sequencer: one read and one write per character, then the
      // rest of the instruction time is waited out before done.
      case (s_q.state)
         ftrc_pkg::FTRC_IDLE: begin
            if (start && isCopy) begin
               s_d.state   = ftrc_pkg::FTRC_READ;
               s_d.srcAddr = qAddr;
               s_d.dstAddr = isBtf ? pAddr - 15'(1) : pAddr; // RULE2
               s_d.pos     = 8'h00;
               s_d.branch  = isBtf;
               s_d.waitCnt = tflCycles;
               if (isBtf) begin
                  s_d.retAddr = instrAddr + `FTRC_INSN_LEN; // RULE2
               end
            end
         end
         ftrc_pkg::FTRC_READ: begin
            memRead     = 1'b1;
            memAddr     = s_q.srcAddr;
            s_d.data    = memRdData;
            s_d.state   = ftrc_pkg::FTRC_WRIT;
         end
         ftrc_pkg::FTRC_WRIT: begin
            memWrite    = 1'b1;
            memAddr     = s_q.dstAddr;
            s_d.srcAddr = s_q.srcAddr - 15'(1);
            s_d.dstAddr = s_q.dstAddr - 15'(1);
            s_d.pos     = s_q.pos + 8'h01;
            if (stopFlag) begin // RULE1 RULE3
               s_d.state = ftrc_pkg::FTRC_WAIT;
            end else begin
               s_d.state = ftrc_pkg::FTRC_READ;
            end
         end
         ftrc_pkg::FTRC_WAIT: begin
            if (s_q.waitCnt == '0) begin
               s_d.state = ftrc_pkg::FTRC_DONE;
            end
         end
         ftrc_pkg::FTRC_DONE: begin
            done      = 1'b1;
            s_d.state = ftrc_pkg::FTRC_IDLE;
         end
         default: begin
            s_d.state = ftrc_pkg::FTRC_IDLE;
         end
      endcase

      // The exponent addresses are loaded at operand fetch; a new pair
      // starts with no alignment pending.
      if (expAddrLoad) begin
         s_d.firstExpAddr  = firstExpAddrIn; // RULE15
         s_d.secondExpAddr = secondExpAddrIn; // RULE15
         s_d.expDiff       = 9'h000; // RULE16
      end

      // Result indicators. A divide by zero leaves the dividend as it was,
      // so the high/positive and equal/zero indicators do not react to it.
      if (result.valid) begin
         s_d.expDiff = 9'(result.leadZeros); // RULE16
         if (!result.divZero) begin
            if (ovf) begin
               s_d.ind.ez = 1'b0;
               s_d.ind.hp = !result.negative; // RULE9
            end else if (unf || result.zeroMant) begin
               s_d.ind.ez = 1'b1; // RULE5 RULE10
               s_d.ind.hp = 1'b0;
            end else begin
               s_d.ind.ez = 1'b0;
               s_d.ind.hp = !result.negative; // RULE6
            end
         end
      end

      // Compare never writes storage; it reports through the indicators.
      if (cmpValid) begin
         s_d.ind.hp = cmpGreater && !cmpEqual; // RULE19 RULE20 RULE21
         s_d.ind.ez = cmpEqual; // RULE20 RULE21
      end

      // Clears first, then sets, so that a same-cycle set wins.
      if (acClr) begin
         s_d.ind.ac = 1'b0;
      end
      if (acSet) begin
         s_d.ind.ac = 1'b1; // RULE7
      end
      if (ecClr) begin
         s_d.ind.ec = 1'b0; // RULE13
      end
      if (ecSet) begin
         s_d.ind.ec = 1'b1; // RULE8
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Result analysis. Overflow is tested first: the clamp to the largest
   // value must not be undone by the zero forms below it. The outputs
   // rest at zero while no result is offered.
   always_comb begin
      resultZeroFill = 1'b0;
      resultNineFill = 1'b0;
      resultNegative = 1'b0;
      resultExpNeg   = 1'b0;
      resultExp      = 8'h00;
      if (result.valid) begin
         if (ovf) begin
            resultNineFill = 1'b1; // RULE9
            resultNegative = result.negative; // RULE9
            resultExp      = 8'(`FTRC_EXP_MAX); // RULE9
         end else if (unf || result.zeroMant) begin
            // Special zero: plus zeros with the most negative exponent.
            resultZeroFill = 1'b1; // RULE4 RULE10
            resultExpNeg   = 1'b1; // RULE4 RULE10
            resultExp      = 8'(`FTRC_EXP_MAX); // RULE4 RULE10
         end else begin
            resultNegative = result.negative;
            resultExpNeg   = normExp[8];
            resultExp      = normExp[8] ? 8'(-normExp) : normExp[7:0]; // RULE16
         end
      end
   end

   // Sequencer outputs. The next instruction address is only meaningful
   // at done of a branch transmit, when it points back at the branch target.
   assign memWrData          = s_q.data;
   assign busy               = s_q.state != ftrc_pkg::FTRC_IDLE;
   assign branchTaken        = done && s_q.branch; // RULE2
   assign nextInstrAddr      = s_q.dstAddr + 15'(1) + 15'(s_q.pos);
   assign returnAddress      = s_q.retAddr;
   assign firstExpAddr       = s_q.firstExpAddr;
   assign secondExpAddr      = s_q.secondExpAddr;
   assign expDiff            = s_q.expDiff;
   assign expCheckTestResult = s_q.ind.ec;
   // Either check stops the program only while the switch is set.
   assign checkStop = overflowCheckSw && (s_q.ind.ec || s_q.ind.ac); // RULE12

   ftrc_lamp u_lampHp (
      .ind  (s_q.ind.hp),
      .lamp (lampHighPos)
   );
   ftrc_lamp u_lampEz (
      .ind  (s_q.ind.ez),
      .lamp (lampEqualZero)
   );
   ftrc_lamp u_lampAc (
      .ind  (s_q.ind.ac),
      .lamp (lampArithCheck)
   );
   ftrc_lamp u_lampEc (
      .ind  (s_q.ind.ec),
      .lamp (lampExpCheck)
   );
endmodule

// A console lamp follows its indicator register.
module ftrc_lamp (
   input  wire logic ind,
   output logic      lamp
);
   assign lamp = ind; // RULE14
endmodule

// file: bench/ftrc_unit_sva.sv
`timescale 1ns/1ps
module ftrc_unit_sva (
   input wire logic                   clk_sys,
   input wire logic                   rst_b,
   input wire logic                   done,
   input wire logic                   branchTaken,
   input wire ftrc_pkg::ftrc_result_s result,
   input wire logic                   resultNineFill,
   input wire logic [7:0]             resultExp,
   input wire logic                   resultExpNeg,
   input wire logic                   cmpValid,
   input wire logic                   cmpGreater,
   input wire logic                   cmpEqual,
   input wire logic                   expCheckTest,
   input wire logic                   overflowCheckSw,
   input wire logic                   checkStop,
   input wire logic                   lampHighPos,
   input wire logic                   lampEqualZero,
   input wire logic                   lampArithCheck,
   input wire logic                   lampExpCheck
);
   wire [8:0] normExp = result.expSum - 9'(result.leadZeros);
   wire ovf = result.valid && $signed(normExp) > 9'sh063;
   wire unf = result.valid && $signed(normExp) < -9'sh063;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   branch_with_done_a: assert property (branchTaken |-> done)
      else $error("branch flag without done");
   zero_sets_ez_a: assert property (
      result.valid && result.zeroMant && !ovf && !result.divZero && !cmpValid
      |=> lampEqualZero && !lampHighPos)
      else $error("zero mantissa indicator wrong");
   div_sets_ac_a: assert property (result.valid && result.divZero |=> lampArithCheck)
      else $error("divide by zero not flagged");
   ovf_fill_a: assert property (
      ovf |-> resultNineFill && resultExp == 8'h63 && !resultExpNeg)
      else $error("overflow clamp wrong");
   unf_sets_ec_a: assert property (unf && !result.opZero |=> lampExpCheck)
      else $error("underflow not flagged");
   ec_test_clear_a: assert property (expCheckTest && !result.valid |=> !lampExpCheck)
      else $error("exponent check not cleared");
   cmp_indicators_a: assert property (cmpValid && !result.valid |=>
      lampHighPos == $past(cmpGreater && !cmpEqual) && lampEqualZero == $past(cmpEqual))
      else $error("compare indicators wrong");
   stop_by_switch_a: assert property (
      checkStop == (overflowCheckSw && (lampExpCheck || lampArithCheck)))
      else $error("check stop mismatch");
   cover property (done && branchTaken);
   cover property (ovf);
   cover property (cmpValid && cmpEqual);
endmodule
bind ftrc_unit ftrc_unit_sva u_sva (.*);

// file: bench/ftrc_unit_tb.sv
`timescale 1ns/1ps
module ftrc_unit_tb;
   logic                   clk_sys = 1'b0;
   logic                   rst_b = 1'b0;
   logic                   start, memRead, memWrite, busy, done, branchTaken;
   logic                   resultZeroFill, resultNineFill, resultNegative, resultExpNeg;
   logic                   cmpValid, cmpGreater, cmpEqual, expAddrLoad, expCheckTest;
   logic                   operatorReset, overflowCheckSw, expCheckTestResult, checkStop;
   logic                   lampHighPos, lampEqualZero, lampArithCheck, lampExpCheck;
   logic [6:0]             opCode;
   logic [7:0]             mantLen, resultExp;
   logic [8:0]             expDiff;
   logic [14:0]            pAddr, qAddr, instrAddr, memAddr, nextInstrAddr, returnAddress;
   logic [14:0]            firstExpAddrIn, secondExpAddrIn, firstExpAddr, secondExpAddr;
   ftrc_pkg::ftrc_char_s   memWrData, memRdData;
   ftrc_pkg::ftrc_result_s result;
   ftrc_pkg::ftrc_char_s   mem [64];
   int                     mismatches, check_count, cycles, n;

   ftrc_unit dut (.*);

   always #25 clk_sys = ~clk_sys;
   // Storage answers only while read is strobed.
   assign memRdData = memRead ? mem[memAddr[5:0]] : 5'h1F;
   always @(posedge clk_sys) begin
      if (memWrite)
         mem[memAddr[5:0]] <= memWrData;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end

   function automatic logic [4:0] orig(input int a);
      return {a[3:0], a inside {16, 18, 19, 20, 27, 28, 29, 30}};
   endfunction

   task automatic final_report();
      if (mismatches == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic xfer(input logic [6:0] op, input logic [14:0] p, input logic [14:0] q);
      @(negedge clk_sys);
      {opCode, pAddr, qAddr, start} = {op, p, q, 1'b1};
      @(negedge clk_sys);
      start = 1'b0;
      chk(busy, 1);
      n = 1;
      while (done !== 1'b1 && n < 12000) begin
         @(negedge clk_sys);
         n++;
      end
   endtask

   task automatic field_chk(input int p, input int q, input int len);
      for (int k = -1; k <= len; k++)
         chk(mem[p-k], orig(k >= 0 && k < len ? q - k : p - k));
   endtask

   task automatic res(input logic [8:0] e, input logic ng, zm, dz, oz, input logic [4:0] ex);
      @(negedge clk_sys);
      result = '{1'b1, ng, zm, dz, oz, e, 8'h00};
      #1 chk({resultZeroFill, resultNineFill, resultNegative}, ex[4:2]);
      if (ex[4] || ex[3])
         chk({resultExpNeg, resultExp}, {ex[4], 8'h63});
      @(negedge clk_sys);
      result.valid = 1'b0;
      chk({lampHighPos, lampEqualZero}, ex[1:0]);
   endtask

   task automatic ec(input logic x);
      chk({lampExpCheck, checkStop}, {x, x});
      @(negedge clk_sys);
      expCheckTest = 1'b1;
      #1 chk(expCheckTestResult, x);
      @(negedge clk_sys);
      expCheckTest = 1'b0;
      chk(lampExpCheck, 0);
   endtask

   initial begin
      {start, opCode, pAddr, qAddr, result, cmpValid, cmpGreater, cmpEqual} = '0;
      {expAddrLoad, expCheckTest, operatorReset, firstExpAddrIn, secondExpAddrIn} = '0;
      {instrAddr, mantLen, overflowCheckSw} = {15'h0064, 8'h02, 1'b1};
      foreach (mem[i]) mem[i] = orig(i);
      repeat (6) @(negedge clk_sys);
      rst_b = 1'b1;
      xfer(7'h06, 15'h0028, 15'h0014);
      chk(n >= 6396 && n <= 6404, 1);
      chk(branchTaken, 0);
      field_chk(40, 20, 5);
      xfer(7'h07, 15'h0032, 15'h001E);
      chk({branchTaken, nextInstrAddr, returnAddress}, {1'b1, 15'h0032, 15'h0070});
      field_chk(49, 30, 4);
      res(9'h005, 0, 0, 0, 0, 5'b00010);
      @(negedge clk_sys);
      result = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 9'h008, 8'h03};
      #1 chk({resultExpNeg, resultExp}, 9'h005);
      @(negedge clk_sys);
      result.valid = 1'b0;
      chk(expDiff, 9'h003);
      res(9'h005, 0, 1, 0, 0, 5'b10001);
      ec(0);
      res(9'h064, 0, 0, 0, 0, 5'b01010);
      ec(1);
      res(9'h064, 1, 0, 0, 0, 5'b01100);
      ec(1);
      res(9'h19C, 1, 0, 0, 0, 5'b10001);
      ec(1);
      res(9'h19C, 0, 1, 0, 1, 5'b10001);
      ec(0);
      res(9'h005, 1, 0, 1, 0, 5'b00101);
      chk({lampArithCheck, checkStop}, 2'b11);
      overflowCheckSw = 1'b0;
      #1 chk(checkStop, 0);
      overflowCheckSw = 1'b1;
      operatorReset = 1'b1;
      @(negedge clk_sys);
      operatorReset = 1'b0;
      chk({lampArithCheck, checkStop}, 2'b00);
      for (int i = 0; i < 3; i++) begin
         @(negedge clk_sys);
         {cmpValid, cmpGreater, cmpEqual} = {1'b1, i == 0, i == 2};
         @(negedge clk_sys);
         cmpValid = 1'b0;
         chk({lampHighPos, lampEqualZero}, {i == 0, i == 2});
      end
      @(negedge clk_sys);
      {firstExpAddrIn, secondExpAddrIn, expAddrLoad} = {15'h1234, 15'h0567, 1'b1};
      @(negedge clk_sys);
      expAddrLoad = 1'b0;
      chk({firstExpAddr, secondExpAddr}, {15'h1234, 15'h0567});
      chk(expDiff, 9'h000);
      final_report();
   end
endmodule
